// File: stb_pkg.sv
package stb_pkg;

  // ==========================================================================
  // Register map (byte addresses on the plain register port)
  // ==========================================================================
  localparam logic [7:0] STB_SECONDARY_TIMEBASE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] STB_PRIMARY_TIMEBASE_CONTROL_ADDR   = 8'h04;
  localparam logic [7:0] STB_SECONDARY_PERIOD_ADDR           = 8'h08;
  localparam logic [7:0] STB_ACTIVE_PERIOD_ADDR              = 8'h0c;
  localparam logic [7:0] STB_IRQ_STATUS_ADDR                 = 8'h10;
  localparam logic [7:0] STB_IRQ_MASK_ADDR                   = 8'h14;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned STB_ADDR_W = 8;
  localparam int unsigned STB_DATA_W = 16;
  localparam int unsigned STB_CNT_W  = 16;
  localparam int unsigned STB_PS_W   = 4;
  localparam int unsigned STB_SRC_W  = 3;
  localparam int unsigned STB_NSYNC  = 3;
  localparam int unsigned STB_NIRQ   = 4;

  // ==========================================================================
  // Secondary control register fields
  // ==========================================================================
  localparam int unsigned STB_EVT_STATUS_BIT = 12;
  localparam int unsigned STB_EVT_IRQ_EN_BIT = 11;
  localparam int unsigned STB_IMM_UPDATE_BIT = 10;
  localparam int unsigned STB_SPOL_BIT    = 9;
  localparam int unsigned STB_SOEN_BIT    = 8;
  localparam int unsigned STB_SEN_BIT     = 7;
  localparam int unsigned STB_SRC_LSB     = 4;
  localparam int unsigned STB_PS_LSB      = 0;
  localparam logic [15:0] STB_SCTL_WMASK  = 16'h0fff;

  // Primary control register fields
  localparam int unsigned STB_TB_ENABLE_BIT = 15;
  localparam logic [15:0] STB_PCTL_WMASK  = 16'h800f;

  // ==========================================================================
  // Sync source codes
  // ==========================================================================
  localparam logic [2:0] STB_SRC_IN1 = 3'h0;
  localparam logic [2:0] STB_SRC_IN2 = 3'h1;
  localparam logic [2:0] STB_SRC_IN3 = 3'h2;

  // ==========================================================================
  // Interrupt status bits
  // ==========================================================================
  localparam int unsigned STB_IRQ_SEC_EVT  = 0;
  localparam int unsigned STB_IRQ_PRI_EVT  = 1;
  localparam int unsigned STB_IRQ_SEC_WRAP = 2;
  localparam int unsigned STB_IRQ_EXT_SYNC = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] STB_CTL_RST    = 16'h0000;
  localparam logic [15:0] STB_PERIOD_RST = 16'hffff;
  localparam int unsigned STB_SYNC_PULSE_CYC = 1;

endpackage : stb_pkg

// File: stb_postscaler.sv
`timescale 1ns/1ns
`default_nettype none

module stb_postscaler
  import stb_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // Control
  input  wire logic [STB_PS_W-1:0] ratio,
  input  wire logic                clear,
  // Events
  input  wire logic                match,
  output logic                     trigger
);

  typedef struct packed {
    logic [STB_PS_W-1:0] count;
    logic                trigger;
  } stb_ps_state_t;

  stb_ps_state_t state_q;
  stb_ps_state_t state_d;

  // Emits one trigger on every (ratio+1)-th match
  always_comb begin
    state_d         = state_q;
    state_d.trigger = 1'b0;
    if (clear) begin
      state_d.count = '0;
    end else if (match) begin
      if (state_q.count >= ratio) begin
        state_d.count   = '0;
        state_d.trigger = 1'b1;
      end else begin
        state_d.count = state_q.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign trigger = state_q.trigger;

endmodule : stb_postscaler

`default_nettype wire

// File: stb_timebase.sv
`timescale 1ns/1ns
`default_nettype none

module stb_timebase
  import stb_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Register port
  input  wire logic [STB_ADDR_W-1:0] reg_addr,
  input  wire logic [STB_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [STB_DATA_W-1:0] reg_rdata,
  // Time base events
  input  wire logic                  secondary_compare_match,
  input  wire logic                  primary_compare_match,
  input  wire logic                  special_event_ack,
  // Sync pins
  input  wire logic [STB_NSYNC-1:0]  sync_input_n,
  output logic                       secondary_sync_output,
  output logic                       secondary_sync_output_oe,
  // Results
  output logic                       secondary_event_trigger,
  output logic                       primary_event_trigger,
  output logic                       special_event_irq,
  output logic                       irq,
  output logic      [STB_CNT_W-1:0]  secondary_count
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0]          sctl;
    logic [15:0]          pctl;
    logic [15:0]          period_buf;
    logic [15:0]          period_act;
    logic                 period_pend;
    logic [STB_CNT_W-1:0] count;
    logic [STB_NIRQ-1:0]  irq_stat;
    logic [STB_NIRQ-1:0]  irq_mask;
    logic                 sync_in_prev;
    logic                 sync_out;
    logic                 sync_oe;
    logic                 se_irq;
    logic                 irq;
    logic [15:0]          rdata;
  } stb_state_t;

  stb_state_t state_q;
  stb_state_t state_d;

  logic sec_trig;
  logic pri_trig;

  // ==========================================================================
  // Postscalers
  // ==========================================================================
  stb_postscaler u_sec_ps (
    .clock   (clock),
    .reset   (reset),
    .ratio   (state_q.sctl[STB_PS_LSB +: STB_PS_W]),
    .clear   (1'b0),
    .match   (secondary_compare_match),
    .trigger (sec_trig)
  );

  stb_postscaler u_pri_ps (
    .clock   (clock),
    .reset   (reset),
    .ratio   (state_q.pctl[STB_PS_LSB +: STB_PS_W]),
    .clear   (~state_q.pctl[STB_TB_ENABLE_BIT]),
    .match   (primary_compare_match),
    .trigger (pri_trig)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic                 sync_sel;
  logic                 sync_act;
  logic                 sync_edge;
  logic                 wrap;
  logic [STB_NIRQ-1:0]  events;
  logic [STB_NIRQ-1:0]  w1c;
  logic                 wr_sctl;

  always_comb begin
    state_d = state_q;
    wr_sctl = reg_write && (reg_addr == STB_SECONDARY_TIMEBASE_CONTROL_ADDR);

    // Input selection and polarity
    case (state_q.sctl[STB_SRC_LSB +: STB_SRC_W])
      STB_SRC_IN1: sync_sel = sync_input_n[0];
      STB_SRC_IN2: sync_sel = sync_input_n[1];
      STB_SRC_IN3: sync_sel = sync_input_n[2];
      default:     sync_sel = state_q.sctl[STB_SPOL_BIT];      // Reserved codes stay inactive
    endcase
    sync_act  = sync_sel ^ state_q.sctl[STB_SPOL_BIT];
    sync_edge = sync_act && !state_q.sync_in_prev && state_q.sctl[STB_SEN_BIT];
    // History follows the pin even while sync is off, so enabling it fakes no edge
    state_d.sync_in_prev = sync_act;

    // Secondary counter
    wrap = (state_q.count >= state_q.period_act);
    if (sync_edge || wrap) begin
      state_d.count = '0;
    end else begin
      state_d.count = state_q.count + 16'h0001;
    end

    // Period load
    // A write on a boundary wins; without immediate update the new value then waits for the next boundary
    if (reg_write && (reg_addr == STB_SECONDARY_PERIOD_ADDR)) begin
      state_d.period_buf = reg_wdata;
      if (state_q.sctl[STB_IMM_UPDATE_BIT]) begin
        state_d.period_act  = reg_wdata;
        state_d.period_pend = 1'b0;
      end else begin
        state_d.period_pend = 1'b1;
      end
    end else if (state_q.period_pend && (wrap || sync_edge)) begin
      state_d.period_act  = state_q.period_buf;
      state_d.period_pend = 1'b0;
    end

    // Sync output: one cycle active pulse on wrap
    state_d.sync_oe  = state_q.sctl[STB_SOEN_BIT];
    state_d.sync_out = state_q.sctl[STB_SPOL_BIT] ^
                       (wrap && state_q.sctl[STB_SOEN_BIT]);

    // Control registers
    if (wr_sctl) begin
      state_d.sctl = (state_q.sctl & ~STB_SCTL_WMASK) | (reg_wdata & STB_SCTL_WMASK);
    end
    if (reg_write && (reg_addr == STB_PRIMARY_TIMEBASE_CONTROL_ADDR)) begin
      state_d.pctl = reg_wdata & STB_PCTL_WMASK;
    end

    // Special event status: set wins over hardware clear
    if (sec_trig) begin
      state_d.sctl[STB_EVT_STATUS_BIT] = 1'b1;
    end else if (special_event_ack) begin
      state_d.sctl[STB_EVT_STATUS_BIT] = 1'b0;
    end
    state_d.se_irq = state_d.sctl[STB_EVT_STATUS_BIT] &&
                     state_d.sctl[STB_EVT_IRQ_EN_BIT];

    // Sticky interrupt status
    events = '0;
    events[STB_IRQ_SEC_EVT]  = sec_trig && state_q.sctl[STB_EVT_IRQ_EN_BIT];
    events[STB_IRQ_PRI_EVT]  = pri_trig;
    events[STB_IRQ_SEC_WRAP] = wrap;
    events[STB_IRQ_EXT_SYNC] = sync_edge;
    w1c = '0;
    if (reg_write && (reg_addr == STB_IRQ_STATUS_ADDR)) begin
      w1c = reg_wdata[STB_NIRQ-1:0];
    end
    state_d.irq_stat = (state_q.irq_stat & ~w1c) | events;
    if (reg_write && (reg_addr == STB_IRQ_MASK_ADDR)) begin
      state_d.irq_mask = reg_wdata[STB_NIRQ-1:0];
    end
    state_d.irq = |(state_d.irq_stat & state_d.irq_mask);

    // Read data, one cycle later
    state_d.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        STB_SECONDARY_TIMEBASE_CONTROL_ADDR: state_d.rdata = state_q.sctl;
        STB_PRIMARY_TIMEBASE_CONTROL_ADDR:   state_d.rdata = state_q.pctl;
        STB_SECONDARY_PERIOD_ADDR:           state_d.rdata = state_q.period_buf;
        STB_ACTIVE_PERIOD_ADDR:              state_d.rdata = state_q.period_act;
        STB_IRQ_STATUS_ADDR:                 state_d.rdata = {12'h000, state_q.irq_stat};
        STB_IRQ_MASK_ADDR:                   state_d.rdata = {12'h000, state_q.irq_mask};
        default:                             state_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q            <= '0;
      state_q.period_buf <= STB_PERIOD_RST;
      state_q.period_act <= STB_PERIOD_RST;
      state_q.sctl       <= STB_CTL_RST;
      state_q.pctl       <= STB_CTL_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata                = state_q.rdata;
  assign secondary_sync_output    = state_q.sync_out;
  assign secondary_sync_output_oe = state_q.sync_oe;
  assign secondary_event_trigger  = sec_trig;
  assign primary_event_trigger    = pri_trig;
  assign special_event_irq        = state_q.se_irq;
  assign irq                      = state_q.irq;
  assign secondary_count          = state_q.count;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_irq_req;
    @(posedge clock) disable iff (reset)
      special_event_irq == (state_q.sctl[STB_EVT_STATUS_BIT] && state_q.sctl[STB_EVT_IRQ_EN_BIT]);
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("special event irq mismatch");

  property p_stat_set;
    @(posedge clock) disable iff (reset)
      sec_trig |=> state_q.sctl[STB_EVT_STATUS_BIT];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status flag not set");

  property p_irq_off;
    @(posedge clock) disable iff (reset)
      !state_q.sctl[STB_EVT_IRQ_EN_BIT] && !state_d.sctl[STB_EVT_IRQ_EN_BIT] |=> !special_event_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_imm_period;
    @(posedge clock) disable iff (reset)
      reg_write && reg_addr == STB_SECONDARY_PERIOD_ADDR && state_q.sctl[STB_IMM_UPDATE_BIT]
      |=> state_q.period_act == $past(reg_wdata);
  endproperty
  a_imm_period: assert property (p_imm_period) else $error("immediate period not loaded");

  property p_defer_period;
    @(posedge clock) disable iff (reset)
      reg_write && reg_addr == STB_SECONDARY_PERIOD_ADDR && !state_q.sctl[STB_IMM_UPDATE_BIT]
      |=> state_q.period_act == $past(state_q.period_act);
  endproperty
  a_defer_period: assert property (p_defer_period) else $error("period loaded early");

  property p_oe;
    @(posedge clock) disable iff (reset)
      ##1 secondary_sync_output_oe == $past(state_q.sctl[STB_SOEN_BIT]);
  endproperty
  a_oe: assert property (p_oe) else $error("sync output enable mismatch");

  property p_idle_level;
    @(posedge clock) disable iff (reset)
      !state_q.sctl[STB_SOEN_BIT] |=> secondary_sync_output == $past(state_q.sctl[STB_SPOL_BIT]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("sync output not idle");

  property p_no_ext;
    @(posedge clock) disable iff (reset)
      !state_q.sctl[STB_SEN_BIT] && !wrap |=> state_q.count == $past(state_q.count) + 16'h0001;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("counter reset without sync enable");

  property p_reserved;
    @(posedge clock) disable iff (reset)
      state_q.sctl[STB_SRC_LSB +: STB_SRC_W] > STB_SRC_IN3 |-> !sync_edge;
  endproperty
  a_reserved: assert property (p_reserved) else $error("sync from reserved source");

  property p_boundary_load;
    @(posedge clock) disable iff (reset)
      state_q.period_pend && wrap && !(reg_write && reg_addr == STB_SECONDARY_PERIOD_ADDR)
      |=> state_q.period_act == $past(state_q.period_buf);
  endproperty
  a_boundary_load: assert property (p_boundary_load) else $error("period not loaded at boundary");

  property p_stat_clr;
    @(posedge clock) disable iff (reset)
      special_event_ack && !sec_trig
      |=> !state_q.sctl[STB_EVT_STATUS_BIT];
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status flag not cleared");

  // Sync pin checks
  property p_sync_pulse;
    @(posedge clock) disable iff (reset)
      state_q.sctl[STB_SOEN_BIT] && wrap
      |=> secondary_sync_output != $past(state_q.sctl[STB_SPOL_BIT]);
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync output pulse missing");

  property p_sync_restart;
    @(posedge clock) disable iff (reset)
      state_q.sctl[STB_SEN_BIT] && sync_act && !state_q.sync_in_prev
      |=> secondary_count == '0;
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("counter not restarted by sync");

  property p_sel_input;
    @(posedge clock) disable iff (reset)
      state_q.sctl[STB_SEN_BIT] && state_q.sctl[STB_SRC_LSB +: STB_SRC_W] == STB_SRC_IN2 &&
      sync_input_n[1] != state_q.sctl[STB_SPOL_BIT] && !state_q.sync_in_prev
      |=> secondary_count == '0;
  endproperty
  a_sel_input: assert property (p_sel_input) else $error("second sync input not followed");

  // Postscaler checks
  property p_sec_one;
    @(posedge clock) disable iff (reset)
      secondary_compare_match && state_q.sctl[STB_PS_LSB +: STB_PS_W] == 4'h0
      |=> secondary_event_trigger;
  endproperty
  a_sec_one: assert property (p_sec_one) else $error("secondary trigger missing at ratio one");

  property p_sec_origin;
    @(posedge clock) disable iff (reset)
      secondary_event_trigger
      |-> $past(secondary_compare_match);
  endproperty
  a_sec_origin: assert property (p_sec_origin) else $error("secondary trigger without match");

  property p_pri_one;
    @(posedge clock) disable iff (reset)
      primary_compare_match && state_q.pctl[STB_TB_ENABLE_BIT] && state_q.pctl[STB_PS_LSB +: STB_PS_W] == 4'h0
      |=> primary_event_trigger;
  endproperty
  a_pri_one: assert property (p_pri_one) else $error("primary trigger missing at ratio one");

  property p_pri_hold;
    @(posedge clock) disable iff (reset)
      !state_q.pctl[STB_TB_ENABLE_BIT]
      |=> !primary_event_trigger;
  endproperty
  a_pri_hold: assert property (p_pri_hold) else $error("primary trigger while time base off");

endmodule : stb_timebase

`default_nettype wire

// File: stb_sync_partner.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Far side: external sync sources and sync output consumer
// ==========================================================================
module stb_sync_partner
  import stb_pkg::*;
(
  // Clock
  input  wire logic                 clock,
  // Control from bench
  input  wire logic [STB_NSYNC-1:0] fire,
  input  wire logic                 active_low,
  // Sync pins
  output logic      [STB_NSYNC-1:0] sync_input_n,
  input  wire logic                 sync_out,
  input  wire logic                 sync_out_oe,
  // Observation
  output var int                    pulses
);
  // Idle lines sit at the inactive level of the chosen polarity
  assign sync_input_n = fire ^ {STB_NSYNC{active_low}};

  int seen = 0;
  assign pulses = seen;
  always @(posedge clock) begin
    if (sync_out_oe && (sync_out != active_low)) begin
      seen <= seen + 1;
    end
  end
endmodule : stb_sync_partner

`default_nettype wire

// File: stb_timebase_test.sv
`timescale 1ns/1ns
`default_nettype none

module stb_timebase_test
  import stb_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [7:0] a_ctl = STB_SECONDARY_TIMEBASE_CONTROL_ADDR;
  localparam logic [7:0] a_pri = STB_PRIMARY_TIMEBASE_CONTROL_ADDR;
  localparam logic [7:0] a_per = STB_SECONDARY_PERIOD_ADDR;
  localparam logic [7:0] a_act = STB_ACTIVE_PERIOD_ADDR;
  logic        clock, reset, reg_write, reg_read, sec_m, pri_m, ack, sso, sso_oe, set_o, pet, sei, irq, pol;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cnt, v;
  logic [2:0]  sync_n, fire;
  int          err_total, checks, pulses;

  stb_timebase dut_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .secondary_compare_match(sec_m),
    .primary_compare_match(pri_m), .special_event_ack(ack), .sync_input_n(sync_n),
    .secondary_sync_output(sso), .secondary_sync_output_oe(sso_oe), .secondary_event_trigger(set_o),
    .primary_event_trigger(pet), .special_event_irq(sei), .irq(irq), .secondary_count(cnt));
  stb_sync_partner far_u (.clock(clock), .fire(fire), .active_low(pol), .sync_input_n(sync_n),
    .sync_out(sso), .sync_out_oe(sso_oe), .pulses(pulses));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic expire(input string n);
    err_total++;
    $display("CHECK FAILED %s expected done seen timeout", n);
    conclude();
  endtask : expire

  task automatic edges(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : edges

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
    logic [15:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask : rdc

  task automatic hit(input bit p, output logic t);
    @(posedge clock);
    pri_m <= p;
    sec_m <= !p;
    @(posedge clock);
    pri_m <= 1'b0;
    sec_m <= 1'b0;
    #1 t = p ? pet : set_o;
  endtask : hit

  task automatic wait_cnt(input logic [15:0] lo, input logic [15:0] hi);
    for (int i = 0; i < 2200; i++) begin
      edges(1);
      if (cnt >= lo && cnt <= hi) return;
    end
    expire("count window");
  endtask : wait_cnt

  // Trigger must appear on the n-th match only
  task automatic post(input bit p, input logic [15:0] c, input int n);
    logic t;
    if (p) wr(a_pri, c & 16'h000f);
    wr(p ? a_pri : a_ctl, c);
    for (int i = 0; i < n; i++) begin
      hit(p, t);
      chk(p ? "pri trigger" : "sec trigger", {15'h0, i == n - 1}, {15'h0, t});
    end
  endtask : post

  task automatic ackp;
    @(posedge clock);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    edges(1);
  endtask : ackp

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    rdc(a_ctl, 16'h0000, "ctl reset");
    rdc(a_pri, 16'h0000, "pri reset");
    rdc(a_per, 16'hffff, "period reset");
    rdc(a_act, 16'hffff, "active reset");
    rdc(8'h20, 16'h0000, "unmapped");
    wr(a_ctl, 16'hffff);
    rdc(a_ctl, 16'h0fff, "ctl writable");
    wr(a_ctl, 16'h0000);
    wr(a_ctl, 16'h0400);
    wr(a_per, 16'h0800);
    rdc(a_act, 16'h0800, "immediate load");
    wr(a_ctl, 16'h0000);
    wr(a_per, 16'h0100);
    rdc(a_act, 16'h0800, "deferred load");
    wait_cnt(16'h0000, 16'h0000);
    rdc(a_act, 16'h0100, "boundary load");
  endtask : t_regs

  task automatic t_sout;
    int n0;
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      wr(a_ctl, {6'h0, p[0], 1'b1, 8'h00});
      edges(2);
      chk("oe on", 16'h0001, {15'h0, sso_oe});
      n0 = pulses;
      wait_cnt(16'h0000, 16'h0000);
      edges(2);
      chk("sync pulse", 16'h0001, {15'h0, pulses > n0});
      chk("sync idle", {15'h0, p[0]}, {15'h0, sso});
    end
    wr(a_ctl, 16'h0000);
    edges(2);
    chk("oe off", 16'h0000, {15'h0, sso_oe});
  endtask : t_sout

  // Six selectable cases, then a reserved code and a disabled sync
  task automatic t_sync;
    logic [2:0] s;
    logic       rst;
    for (int k = 0; k < 8; k++) begin
      s = (k == 6) ? 3'h5 : 3'(k % 3);
      rst = k < 6;
      pol <= (k >= 3 && k < 6);
      wr(a_ctl, {6'h0, k >= 3 && k < 6, 1'b0, k != 7, s, 4'h0});
      wait_cnt(16'h0020, 16'h0040);
      @(posedge clock);
      fire <= (k == 6) ? 3'h7 : 3'(1 << (k % 3));
      edges(3);
      chk("sync restart", {15'h0, rst}, {15'h0, cnt < 16'h0008});
      fire <= 3'h0;
    end
    pol <= 1'b0;
    wr(a_ctl, 16'h0000);
  endtask : t_sync

  task automatic t_events;
    post(1'b0, 16'h0800, 1);
    post(1'b0, 16'h0802, 3);
    edges(1);
    chk("irq line set", 16'h0001, {15'h0, sei});
    rdc(a_ctl, 16'h1802, "status set");
    ackp();
    chk("irq line clear", 16'h0000, {15'h0, sei});
    rdc(a_ctl, 16'h0802, "status clear");
    post(1'b0, 16'h000f, 16);
    edges(1);
    chk("irq disabled", 16'h0000, {15'h0, sei});
    ackp();
    post(1'b1, 16'h8000, 1);
    post(1'b1, 16'h8001, 2);
    post(1'b1, 16'h800f, 16);
  endtask : t_events

  task automatic t_irq;
    wr(STB_IRQ_MASK_ADDR, 16'h0000);
    edges(2);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(STB_IRQ_MASK_ADDR, 16'h0002);
    edges(2);
    chk("irq unmasked", 16'h0001, {15'h0, irq});
    rd(STB_IRQ_STATUS_ADDR, v);
    chk("pri status", 16'h0002, v & 16'h0002);
    chk("all status", 16'h000f, v);
    wr(STB_IRQ_STATUS_ADDR, 16'h000f);
    edges(2);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    wr(a_act, 16'h1234);
    rdc(a_act, 16'h0100, "active read only");
  endtask : t_irq

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    reset = 1'b1;
    {reg_write, reg_read, sec_m, pri_m, ack, pol} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    fire = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    $display("test registers and period done");
    t_sout();
    $display("test sync output done");
    t_sync();
    $display("test sync inputs done");
    t_events();
    $display("test postscalers done");
    t_irq();
    $display("test interrupts done");
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clock);
    expire("run time");
  end
endmodule : stb_timebase_test

`default_nettype wire
